// File: hw/edh_pkg.sv
// Purpose: shared constants and types for the external hold/access port
// Assumes: one 100 MHz clock; the processor output clock is derived inside
// Notes:   one half-period H of the output clock is a whole number of clk cycles
package edh_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // H in ns for the derived output clock
  localparam int HALF_PERIOD_NS = 20;
  localparam int H_CYC = (HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_GRANT_MIN_H = 4;
  localparam int HOLD_RELEASE_MIN_H = 2;
  localparam int ACQ_ASSERT_MIN_H = 4;
  localparam int ACQ_RELEASE_MIN_H = 2;
  localparam int DATA_ENABLE_MAX_H = 2;
  localparam int ACQ_ASSERT_MAX_H = 6;
  localparam int ACQ_RELEASE_MAX_H = 4;
  localparam int DATA_FLOAT_MAX_H = 1;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CNT_W = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
  } edh_mem_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              read_not_write;
    logic [DATA_W-1:0] wdata;
  } edh_ext_req_t;
endpackage

// File: hw/edh_port.sv
// Purpose: processor side of external-master hold and memory access
// Assumes: all pins synchronous to clk; external pins active low as named
// Notes:   timing counted in half-periods of output_clock, each H_CYC clk cycles
`timescale 1ns/1ns
module edh_port
  import edh_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // own memory access engine
  input  wire edh_pkg::edh_mem_req_t own_req,
  input  wire logic                 own_busy,
  output logic [ADDR_W-1:0]         addr_out,
  output logic                      addr_oe,
  output logic                      ctrl_oe,
  output logic                      output_clock,
  // hold handshake
  input  wire logic                 hold_req_n,
  output logic                      bus_hold_grant_n,
  // external access
  input  wire logic                 ext_access_request_n,
  output logic                      acquisition_ack_n,
  input  wire logic                 ext_access_strobe_n,
  input  wire logic                 ext_read_not_write,
  input  wire edh_pkg::edh_ext_req_t ext_req,
  // memory side for the master's accesses
  output logic                      mem_rd,
  output logic                      mem_wr,
  output logic [ADDR_W-1:0]         mem_addr,
  output logic [DATA_W-1:0]         mem_wdata,
  input  wire logic [DATA_W-1:0]    mem_rdata,
  // data pins
  output logic [DATA_W-1:0]         data_out,
  output logic                      data_oe
);
  import edh_pkg::*;

  typedef enum logic [2:0] {
    S_OWN, S_FLOAT, S_GRANT_WAIT, S_GRANTED, S_RELEASE, S_RESUME
  } edh_hold_state_t;
  typedef enum logic [1:0] {A_IDLE, A_ASSERT_WAIT, A_ACTIVE, A_RELEASE_WAIT} edh_acq_state_t;

  // half-period divider: h_tick marks each output_clock edge
  logic [CNT_W-1:0] div_ff, nxt_div;
  logic             oclk_ff, nxt_oclk;
  logic             h_tick;
  assign h_tick = (div_ff == CNT_W'(H_CYC - 1));
  always_comb begin
    nxt_div  = h_tick ? '0 : div_ff + 1'b1;
    nxt_oclk = h_tick ? ~oclk_ff : oclk_ff;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff  <= '0;
      oclk_ff <= 1'b0;
    end else begin
      div_ff  <= nxt_div;
      oclk_ff <= nxt_oclk;
    end
  end
  assign output_clock = oclk_ff;

  // hold handshake
  edh_hold_state_t  hst_ff, nxt_hst;
  logic [CNT_W-1:0] hcnt_ff, nxt_hcnt;
  logic             acq_idle;
  always_comb begin
    nxt_hst  = hst_ff;
    nxt_hcnt = hcnt_ff;
    if (h_tick && hcnt_ff != '0) nxt_hcnt = hcnt_ff - 1'b1;
    unique case (hst_ff)
      S_OWN: begin
        // own access must finish first, however early the request comes
        if (!hold_req_n && !own_busy) begin
          nxt_hst  = S_FLOAT;
          nxt_hcnt = CNT_W'(HOLD_GRANT_MIN_H);
        end
      end
      S_FLOAT: nxt_hst = S_GRANT_WAIT;
      S_GRANT_WAIT: begin
        if (hold_req_n) nxt_hst = S_OWN;
        else if (hcnt_ff == '0) nxt_hst = S_GRANTED;
      end
      S_GRANTED: begin
        // a master access in flight keeps the grant until acquisition ends
        if (hold_req_n && acq_idle) begin
          nxt_hst  = S_RELEASE;
          nxt_hcnt = CNT_W'(HOLD_RELEASE_MIN_H);
        end
      end
      S_RELEASE: if (hcnt_ff == '0) nxt_hst = S_RESUME;
      S_RESUME: nxt_hst = S_OWN;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      hst_ff  <= S_OWN;
      hcnt_ff <= '0;
    end else begin
      hst_ff  <= nxt_hst;
      hcnt_ff <= nxt_hcnt;
    end
  end
  logic granted;
  assign granted          = (hst_ff == S_GRANTED) || (hst_ff == S_RELEASE);
  assign bus_hold_grant_n = ~granted;
  // float on leaving S_OWN, at least HOLD_GRANT_MIN_H half-periods before grant; drive again one cycle after it releases
  assign addr_oe = (hst_ff == S_OWN);
  assign ctrl_oe = (hst_ff == S_OWN);
  always_ff @(posedge clk) begin
    if (rst) addr_out <= '0;
    else if (own_req.rd || own_req.wr) addr_out <= own_req.addr;
  end

  // acquisition handshake
  edh_acq_state_t   ast_ff, nxt_ast;
  logic [CNT_W-1:0] acnt_ff, nxt_acnt;
  assign acq_idle = (ast_ff == A_IDLE);
  always_comb begin
    nxt_ast  = ast_ff;
    nxt_acnt = acnt_ff;
    if (h_tick && acnt_ff != '0) nxt_acnt = acnt_ff - 1'b1;
    unique case (ast_ff)
      A_IDLE: begin
        if (granted && !ext_access_request_n) begin
          nxt_ast  = A_ASSERT_WAIT;
          nxt_acnt = CNT_W'(ACQ_ASSERT_MIN_H);
        end
      end
      A_ASSERT_WAIT: begin
        if (ext_access_request_n) nxt_ast = A_IDLE;
        else if (acnt_ff == '0) nxt_ast = A_ACTIVE;
      end
      A_ACTIVE: begin
        if (ext_access_request_n) begin
          nxt_ast  = A_RELEASE_WAIT;
          nxt_acnt = CNT_W'(ACQ_RELEASE_MIN_H);
        end
      end
      A_RELEASE_WAIT: if (acnt_ff == '0) nxt_ast = A_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ast_ff  <= A_IDLE;
      acnt_ff <= '0;
    end else begin
      ast_ff  <= nxt_ast;
      acnt_ff <= nxt_acnt;
    end
  end
  logic acq;
  assign acq               = (ast_ff == A_ACTIVE) || (ast_ff == A_RELEASE_WAIT);
  assign acquisition_ack_n = ~acq;

  // master access: strobe falling edge launches one memory cycle
  logic stb_d_ff, nxt_stb_d;
  logic stb_fall;
  assign nxt_stb_d = ext_access_strobe_n;
  always_ff @(posedge clk) begin
    if (rst) stb_d_ff <= 1'b1;
    else stb_d_ff <= nxt_stb_d;
  end
  // strobe before acquisition is ignored
  assign stb_fall  = acq && stb_d_ff && !ext_access_strobe_n;
  assign mem_rd    = stb_fall && ext_req.read_not_write;
  assign mem_wr    = stb_fall && !ext_req.read_not_write;
  assign mem_addr  = ext_req.addr;
  assign mem_wdata = ext_req.wdata;

  logic [DATA_W-1:0] rdat_ff, nxt_rdat;
  logic              doe_ff, nxt_doe;
  always_comb begin
    nxt_rdat = rdat_ff;
    // memory answers one cycle after mem_rd
    if (acq && ext_read_not_write) nxt_rdat = mem_rdata;
    // one cycle of enable delay: well inside the two half-period limit
    nxt_doe = acq && ext_read_not_write;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rdat_ff <= '0;
      doe_ff  <= 1'b0;
    end else begin
      rdat_ff <= nxt_rdat;
      doe_ff  <= nxt_doe;
    end
  end
  assign data_out = rdat_ff;
  assign data_oe  = doe_ff;

  // checks
  sequence s_hold_low;
    $fell(hold_req_n);
  endsequence
  a_grant_after_own: assert property (@(posedge clk) disable iff (rst)
    $fell(addr_oe) |-> !$past(own_busy))
    else $error("bus released while own access busy");
  a_grant_min_delay: assert property (@(posedge clk) disable iff (rst)
    s_hold_low |-> bus_hold_grant_n [*8])
    else $error("grant too early after hold request");
  a_grant_release_min: assert property (@(posedge clk) disable iff (rst)
    (!bus_hold_grant_n && $rose(hold_req_n) && acq_idle) |-> !bus_hold_grant_n [*4])
    else $error("grant released too early");
  a_float_before_grant: assert property (@(posedge clk) disable iff (rst)
    $fell(bus_hold_grant_n) |-> !addr_oe && !ctrl_oe && !$past(addr_oe))
    else $error("address driven at grant");
  a_drive_after_release: assert property (@(posedge clk) disable iff (rst)
    addr_oe |-> bus_hold_grant_n && $past(bus_hold_grant_n))
    else $error("address driven during grant");
  a_acq_assert_window: assert property (@(posedge clk) disable iff (rst)
    (acq_idle && granted && $fell(ext_access_request_n)) ##1 !ext_access_request_n [*7]
    |-> acquisition_ack_n ##[1:5] !acquisition_ack_n)
    else $error("acquisition outside window");
  a_acq_release_window: assert property (@(posedge clk) disable iff (rst)
    (ast_ff == A_ACTIVE && ext_access_request_n) |-> !acquisition_ack_n [*4]
    ##[1:5] acquisition_ack_n)
    else $error("acquisition release outside window");
  a_data_enable: assert property (@(posedge clk) disable iff (rst)
    (acq && ext_read_not_write) |=> data_oe)
    else $error("read data not driven");
  a_data_float_write: assert property (@(posedge clk) disable iff (rst)
    $fell(ext_read_not_write) |=> !data_oe)
    else $error("data driven during write");
  a_data_float_acq: assert property (@(posedge clk) disable iff (rst)
    $rose(acquisition_ack_n) |-> ##[0:1] !data_oe)
    else $error("data not floated after acquisition");
endmodule

// File: dv/edh_master_model.sv
// Purpose: behavioural external master for the hold/access port
// Assumes: drives 1 ns after the rising edge; idle lines high as if pulled up
// Notes:   n_* count clk edges from its own change (n_doe, n_dfl: from the ack seen) to the answer seen
`timescale 1ns/1ns
module edh_master_model (
  // clock
  input  wire logic                      clk,
  // port answers
  input  wire logic                      bus_hold_grant_n,
  input  wire logic                      acquisition_ack_n,
  input  wire logic                      addr_oe,
  input  wire logic                      ctrl_oe,
  input  wire logic [edh_pkg::DATA_W-1:0] data_out,
  input  wire logic                      data_oe,
  // master drive
  output logic                           hold_req_n,
  output logic                           ext_access_request_n,
  output logic                           ext_access_strobe_n,
  output logic                           ext_read_not_write,
  output edh_pkg::edh_ext_req_t          ext_req
);
  import edh_pkg::*;
  int                n_grant, n_grant_rel, n_acq, n_acq_rel, n_doe, n_dz, n_dfl;
  logic              aoe_g, aoe_r;
  logic [DATA_W-1:0] rdata;

  initial begin
    hold_req_n = 1'b1;
    ext_access_request_n = 1'b1;
    ext_access_strobe_n = 1'b1;
    ext_read_not_write = 1'b1;
    ext_req = '0;
  end

  function automatic logic pick(input int sel);
    case (sel)
      0: return bus_hold_grant_n;
      1: return acquisition_ack_n;
      default: return data_oe;
    endcase
  endfunction

  task automatic wait_for(input int sel, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (pick(sel) !== lvl && n < 40);
  endtask

  task automatic access(input logic rnw, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
    n_dz = 0;
    hold_req_n = 1'b0;
    wait_for(0, 1'b0, n_grant);
    aoe_g = addr_oe | ctrl_oe;
    ext_access_request_n = 1'b0;
    wait_for(1, 1'b0, n_acq);
    // read line still idles high, so the port starts driving first
    wait_for(2, 1'b1, n_doe);
    ext_read_not_write = rnw;
    ext_req = '{addr: a, read_not_write: rnw, wdata: w};
    if (!rnw) wait_for(2, 1'b0, n_dz);
    else begin
      // one edge of setup for address and direction before the strobe
      @(posedge clk);
      #1;
    end
    ext_access_strobe_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rdata = data_out;
    ext_access_strobe_n = 1'b1;
    ext_req = ~ext_req;
    ext_read_not_write = 1'b1;
    ext_access_request_n = 1'b1;
    wait_for(1, 1'b1, n_acq_rel);
    wait_for(2, 1'b0, n_dfl);
    hold_req_n = 1'b1;
    wait_for(0, 1'b1, n_grant_rel);
    aoe_r = addr_oe | ctrl_oe;
  endtask
endmodule

// File: dv/tb.sv
// Purpose: self-checking bench for the hold/access port
// Assumes: H_CYC clk cycles per half-period; master model on the far side
// Notes:   one master access per scenario, counted in clk edges
`timescale 1ns/1ns
module tb;
  import edh_pkg::*;
  logic              clk, rst, own_busy, addr_oe, ctrl_oe, output_clock;
  logic              bus_hold_grant_n, acquisition_ack_n, mem_rd, mem_wr, data_oe;
  logic              hold_req_n, ext_access_request_n, ext_access_strobe_n;
  logic              ext_read_not_write;
  edh_mem_req_t      own_req;
  edh_ext_req_t      ext_req;
  logic [ADDR_W-1:0] addr_out, mem_addr, rd_a, wr_a;
  logic [DATA_W-1:0] mem_rdata, mem_wdata, data_out, wr_d;
  int                mismatches, checked, cycles;

  edh_port dut (.clk(clk), .rst(rst), .own_req(own_req), .own_busy(own_busy),
    .addr_out(addr_out), .addr_oe(addr_oe), .ctrl_oe(ctrl_oe), .output_clock(output_clock),
    .hold_req_n(hold_req_n), .bus_hold_grant_n(bus_hold_grant_n),
    .ext_access_request_n(ext_access_request_n), .acquisition_ack_n(acquisition_ack_n),
    .ext_access_strobe_n(ext_access_strobe_n), .ext_read_not_write(ext_read_not_write),
    .ext_req(ext_req), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .data_out(data_out), .data_oe(data_oe));
  edh_master_model master (.clk(clk), .bus_hold_grant_n(bus_hold_grant_n),
    .acquisition_ack_n(acquisition_ack_n), .addr_oe(addr_oe), .ctrl_oe(ctrl_oe),
    .data_out(data_out), .data_oe(data_oe), .hold_req_n(hold_req_n),
    .ext_access_request_n(ext_access_request_n), .ext_access_strobe_n(ext_access_strobe_n),
    .ext_read_not_write(ext_read_not_write), .ext_req(ext_req));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mem_rd === 1'b1) rd_a <= mem_addr;
    if (mem_wr === 1'b1) begin
      wr_a <= mem_addr;
      wr_d <= mem_wdata;
    end
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic rng(input string nm, input int lo, input int hi, input int seen);
    checked++;
    if (seen < lo || seen > hi) begin
      mismatches++;
      $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, seen);
    end
  endtask

  task automatic eqv(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_read;
    mem_rdata = 16'h5a3c;
    master.access(1'b1, 16'h0123, 16'h0000);
    rng("grant delay", HOLD_GRANT_MIN_H * H_CYC, 39, master.n_grant);
    rng("acq delay", ACQ_ASSERT_MIN_H * H_CYC, ACQ_ASSERT_MAX_H * H_CYC, master.n_acq);
    rng("acq release", ACQ_RELEASE_MIN_H * H_CYC, ACQ_RELEASE_MAX_H * H_CYC,
        master.n_acq_rel);
    rng("grant release", HOLD_RELEASE_MIN_H * H_CYC, 39, master.n_grant_rel);
    rng("data enable", 1, DATA_ENABLE_MAX_H * H_CYC, master.n_doe);
    rng("data float", 1, DATA_FLOAT_MAX_H * H_CYC, master.n_dfl);
    eqv("bus float", 16'h0000, {15'h0, master.aoe_g});
    eqv("bus resume", 16'h0000, {15'h0, master.aoe_r});
    eqv("read data", 16'h5a3c, master.rdata);
    eqv("read addr", 16'h0123, rd_a);
    $display("test read done");
  endtask

  task automatic test_write;
    master.access(1'b0, 16'h4321, 16'hbeef);
    rng("write float", 1, H_CYC, master.n_dz);
    eqv("write addr", 16'h4321, wr_a);
    eqv("write data", 16'hbeef, wr_d);
    $display("test write done");
  endtask

  task automatic test_busy;
    logic oc;
    own_req = '{addr: 16'h0777, rd: 1'b1, wr: 1'b0};
    own_busy = 1'b1;
    fork
      master.access(1'b1, 16'h0042, 16'h0000);
      begin
        repeat (20) @(posedge clk);
        #1;
        own_busy = 1'b0;
        own_req = '0;
      end
    join
    rng("busy grant", 21, 39, master.n_grant);
    eqv("own addr", 16'h0777, addr_out);
    @(posedge clk);
    #1;
    eqv("bus driven", 16'h0001, {15'h0, addr_oe});
    oc = output_clock;
    repeat (H_CYC) @(posedge clk);
    #1;
    eqv("output clock", {15'h0, ~oc}, {15'h0, output_clock});
    $display("test busy done");
  endtask

  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    own_req = '0;
    own_busy = 1'b0;
    mem_rdata = '0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    test_read();
    test_write();
    test_busy();
    complete_run();
  end
endmodule
